// [strap_pkg.sv]
/*
 * constants for the strap latch: pad indices, register offsets, field
 * positions and values after reset.
 * assumes a 32-bit classic wishbone register bus with byte addresses.
 */
package strap_pkg;

    // ------------------------------------------------------------------
    // strap pad indices
    // ------------------------------------------------------------------
    localparam int unsigned NUM_PADS = 12;
    localparam int unsigned IDX_MGMT_ADDR_STRAP_BIT0 = 0;
    localparam int unsigned IDX_MGMT_ADDR_STRAP_BIT1 = 1;
    localparam int unsigned IDX_MGMT_ADDR_STRAP_BIT2 = 2;
    localparam int unsigned IDX_MODE_STRAP_BIT0 = 3;
    localparam int unsigned IDX_MODE_STRAP_BIT1 = 4;
    localparam int unsigned IDX_MODE_STRAP_BIT2 = 5;
    localparam int unsigned IDX_ISOLATE_STRAP = 6;
    localparam int unsigned IDX_SPEED_STRAP = 7;
    localparam int unsigned IDX_DUPLEX_STRAP = 8;
    localparam int unsigned IDX_AUTONEG_ENABLE_STRAP = 9;
    localparam int unsigned IDX_BROADCAST_DISABLE_STRAP = 10;
    localparam int unsigned IDX_NAND_TREE_STRAP_N = 11;

    // ------------------------------------------------------------------
    // mode codes and address
    // ------------------------------------------------------------------
    localparam logic [2:0] MODE_RMII = 3'h1;
    localparam logic [2:0] MODE_RMII_B2B = 3'h5;
    localparam logic [1:0] MGMT_ADDR_UPPER = 2'h0;
    localparam logic [4:0] MGMT_ADDR_BCAST = 5'h00;

    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_BASIC_CTRL = 8'h00;
    localparam logic [7:0] OFS_AN_ADVERT = 8'h04;
    localparam logic [7:0] OFS_STRAP_STATUS = 8'h08;

    // ------------------------------------------------------------------
    // basic control fields
    // ------------------------------------------------------------------
    localparam int unsigned CTRL_SPEED_BIT = 13;
    localparam int unsigned CTRL_AUTONEG_BIT = 12;
    localparam int unsigned CTRL_ISOLATE_BIT = 10;
    localparam int unsigned CTRL_DUPLEX_BIT = 8;
    localparam logic [15:0] CTRL_WMASK = 16'h3500;
    localparam logic [15:0] CTRL_RESET = 16'h3100;

    // ------------------------------------------------------------------
    // advertisement fields
    // ------------------------------------------------------------------
    localparam logic [15:0] ADV_100_CAPS = 16'h0180;
    localparam logic [15:0] ADV_WMASK = 16'h01e0;
    localparam logic [15:0] ADV_RESET = 16'h01e1;

    // ------------------------------------------------------------------
    // strap status fields
    // ------------------------------------------------------------------
    localparam int unsigned STAT_ADDR_LSB = 0;
    localparam int unsigned STAT_MODE_LSB = 5;
    localparam int unsigned STAT_BCAST_BIT = 8;
    localparam int unsigned STAT_NAND_BIT = 9;
    localparam int unsigned STAT_RSVD_MODE_BIT = 10;
    localparam int unsigned STAT_VALID_BIT = 15;

endpackage

// [strap_cfg_if.sv]
/*
 * carrier between the strap latch and its register file.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface strap_cfg_if;
    logic load;
    logic valid;
    logic isolate;
    logic speed;
    logic duplex;
    logic autoneg;
    logic [15:0] status;
    logic [15:0] ctrl;
    logic [15:0] adv;

    modport src (output load, output valid, output isolate, output speed, output duplex,
        output autoneg, output status, input ctrl, input adv);
    modport regs (input load, input valid, input isolate, input speed, input duplex,
        input autoneg, input status, output ctrl, output adv);
endinterface

// [strap_sync.sv]
/*
 * two-flop synchroniser for a vector of pad levels.
 * assumes the pads are static or slow against clk; no reset so the
 * levels are tracked while the chip reset is held.
 */
`timescale 1ns/1ps
module strap_sync #(
    parameter int unsigned W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    always_ff @(posedge clk) begin
        meta_r <= d;
        q_r <= meta_r;
    end

    assign q = q_r;
endmodule

// [strap_regs.sv]
/*
 * wishbone classic slave holding basic control and advertisement words
 * and passing through the strap status word.
 * assumes load pulses once, at the first edge after reset release.
 */
`timescale 1ns/1ps
module strap_regs
    import strap_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    strap_cfg_if.regs cfg
);
    logic [15:0] ctrl_r, ctrl_nxt;
    logic [15:0] adv_r, adv_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic ack_r, ack_nxt;
    logic [15:0] wmask;
    logic [15:0] wdata;
    logic wr;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        ctrl_nxt = ctrl_r;
        adv_nxt = adv_r;
        dat_nxt = dat_r;
        wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        wdata = wb_dat_i[15:0];
        ack_nxt = wb_cyc_i && wb_stb_i && !ack_r && cfg.valid;
        wr = ack_nxt && wb_we_i;
        if (cfg.load) begin
            // strap levels seed the control bits
            ctrl_nxt = CTRL_RESET;
            ctrl_nxt[CTRL_ISOLATE_BIT] = cfg.isolate;
            ctrl_nxt[CTRL_SPEED_BIT] = cfg.speed;
            ctrl_nxt[CTRL_DUPLEX_BIT] = cfg.duplex;
            ctrl_nxt[CTRL_AUTONEG_BIT] = cfg.autoneg;
            adv_nxt = cfg.speed ? ADV_RESET : (ADV_RESET & ~ADV_100_CAPS);
        end else if (wr && wb_adr_i == OFS_BASIC_CTRL) begin
            ctrl_nxt = (ctrl_r & ~(wmask & CTRL_WMASK)) | (wdata & wmask & CTRL_WMASK);
        end else if (wr && wb_adr_i == OFS_AN_ADVERT) begin
            adv_nxt = (adv_r & ~(wmask & ADV_WMASK)) | (wdata & wmask & ADV_WMASK);
        end
        if (ack_nxt) begin
            unique case (wb_adr_i)
                OFS_BASIC_CTRL: dat_nxt = {16'h0000, ctrl_r};
                OFS_AN_ADVERT: dat_nxt = {16'h0000, adv_r};
                OFS_STRAP_STATUS: dat_nxt = {16'h0000, cfg.status};
                default: dat_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= CTRL_RESET;
            adv_r <= ADV_RESET;
            dat_r <= 32'h0000_0000;
            ack_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            adv_r <= adv_nxt;
            dat_r <= dat_nxt;
            ack_r <= ack_nxt;
        end
    end

    assign wb_dat_o = dat_r;
    assign wb_ack_o = ack_r;
    assign cfg.ctrl = ctrl_r;
    assign cfg.adv = adv_r;
endmodule

// [phy_strap_latch_rmii.sv]
/*
 * strap-in latch of a 10/100 rmii phy: samples the strap pads at chip
 * reset release, seeds control and advertisement bits, holds the rest,
 * then hands the pads back to their normal output functions.
 * assumes board pulls keep the pads steady while nrst is low.
 */
// Local design decisions: the register addresses and the Wishbone register port.
// Function
// - latch three low address straps at release
// - address bits four and three stay zero
// - address zero is own only if broadcast disabled
// - latch mode straps: 001 rmii, 101 back-to-back
// - isolate strap seeds control bit ten
// - speed strap seeds control bit thirteen
// - speed strap also sets advertised speed capability
// - duplex strap seeds control bit eight
// - autoneg strap seeds control bit twelve
// - broadcast disable strap held internally only; code also reports it in strap status bit eight
// - disable high: address zero unique to device
// - disable low: address zero also broadcast
// - active-low test strap enables nand tree
// - pads inputs during reset, outputs afterwards
`timescale 1ns/1ps
module phy_strap_latch_rmii
    import strap_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [strap_pkg::NUM_PADS-1:0] strap_pad_in,
    output logic [strap_pkg::NUM_PADS-1:0] strap_pad_out,
    output logic [strap_pkg::NUM_PADS-1:0] strap_pad_oe,
    input wire logic [strap_pkg::NUM_PADS-1:0] func_out,
    input wire logic [4:0] mgmt_frame_addr,
    output logic mgmt_addr_hit,
    output logic straps_valid,
    output logic [4:0] phy_addr,
    output logic rmii_mode_en,
    output logic rmii_b2b_en,
    output logic mode_reserved,
    output logic isolate_en,
    output logic speed_100,
    output logic duplex_half,
    output logic autoneg_en,
    output logic nand_tree_en
);
    import strap_pkg::*;

    // ------------------------------------------------------------------
    // pad synchroniser
    // ------------------------------------------------------------------
    logic [NUM_PADS-1:0] pad_sync;

    strap_sync #(
        .W(NUM_PADS)
    ) u_sync (
        .clk(clk),
        .d(strap_pad_in),
        .q(pad_sync)
    );

    // ------------------------------------------------------------------
    // capture at release
    // ------------------------------------------------------------------
    logic valid_r, valid_nxt;
    logic [2:0] addr_r, addr_nxt;
    logic [2:0] mode_r, mode_nxt;
    logic bcast_dis_r, bcast_dis_nxt;
    logic nand_en_r, nand_en_nxt;
    logic [NUM_PADS-1:0] pad_out_r, pad_out_nxt;
    logic capture;

    strap_cfg_if cfg ();

    always_comb begin
        capture = !valid_r;
        valid_nxt = 1'b1;
        addr_nxt = addr_r;
        mode_nxt = mode_r;
        bcast_dis_nxt = bcast_dis_r;
        nand_en_nxt = nand_en_r;
        pad_out_nxt = func_out;
        if (capture) begin
            addr_nxt = {pad_sync[IDX_MGMT_ADDR_STRAP_BIT2], pad_sync[IDX_MGMT_ADDR_STRAP_BIT1],
                pad_sync[IDX_MGMT_ADDR_STRAP_BIT0]};
            mode_nxt = {pad_sync[IDX_MODE_STRAP_BIT2], pad_sync[IDX_MODE_STRAP_BIT1],
                pad_sync[IDX_MODE_STRAP_BIT0]};
            bcast_dis_nxt = pad_sync[IDX_BROADCAST_DISABLE_STRAP];
            nand_en_nxt = !pad_sync[IDX_NAND_TREE_STRAP_N];
        end
    end

    // latched copies change only on the capture edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            valid_r <= 1'b0;
            addr_r <= 3'h0;
            mode_r <= 3'h0;
            bcast_dis_r <= 1'b0;
            nand_en_r <= 1'b0;
            pad_out_r <= '0;
        end else begin
            valid_r <= valid_nxt;
            addr_r <= addr_nxt;
            mode_r <= mode_nxt;
            bcast_dis_r <= bcast_dis_nxt;
            nand_en_r <= nand_en_nxt;
            pad_out_r <= pad_out_nxt;
        end
    end

    // ------------------------------------------------------------------
    // register file link
    // ------------------------------------------------------------------
    assign cfg.load = capture;
    assign cfg.valid = valid_r;
    assign cfg.isolate = pad_sync[IDX_ISOLATE_STRAP];
    assign cfg.speed = pad_sync[IDX_SPEED_STRAP];
    assign cfg.duplex = pad_sync[IDX_DUPLEX_STRAP];
    assign cfg.autoneg = pad_sync[IDX_AUTONEG_ENABLE_STRAP];
    assign cfg.status = {valid_r, 4'h0, mode_reserved, nand_en_r, bcast_dis_r, mode_r,
        phy_addr};

    strap_regs u_regs (
        .clk(clk),
        .nrst(nrst),
        .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i),
        .wb_we_i(wb_we_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .cfg(cfg)
    );

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign phy_addr = {MGMT_ADDR_UPPER, addr_r};
    assign rmii_mode_en = valid_r && (mode_r == MODE_RMII);
    assign rmii_b2b_en = valid_r && (mode_r == MODE_RMII_B2B);
    // board must avoid other codes; flagged, not acted on
    assign mode_reserved = valid_r && !rmii_mode_en && !rmii_b2b_en;
    assign isolate_en = cfg.ctrl[CTRL_ISOLATE_BIT];
    assign speed_100 = cfg.ctrl[CTRL_SPEED_BIT];
    assign duplex_half = cfg.ctrl[CTRL_DUPLEX_BIT];
    assign autoneg_en = cfg.ctrl[CTRL_AUTONEG_BIT];
    assign nand_tree_en = nand_en_r;
    assign straps_valid = valid_r;

    // own address, plus address zero as broadcast unless disabled
    assign mgmt_addr_hit = valid_r && ((mgmt_frame_addr == phy_addr) ||
        ((mgmt_frame_addr == MGMT_ADDR_BCAST) && !bcast_dis_r));

    // pads are inputs until the capture, then drive their functions
    assign strap_pad_oe = {NUM_PADS{valid_r}};
    assign strap_pad_out = pad_out_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_capture;
        $rose(valid_r);
    endsequence

    sequence s_settled;
        valid_r ##1 valid_r;
    endsequence

    a_addr_capture: assert property (s_capture |-> phy_addr[2:0] ==
        $past({pad_sync[IDX_MGMT_ADDR_STRAP_BIT2], pad_sync[IDX_MGMT_ADDR_STRAP_BIT1],
        pad_sync[IDX_MGMT_ADDR_STRAP_BIT0]}))
        else $error("address strap not captured");

    a_addr_upper: assert property (phy_addr[4:3] == 2'h0)
        else $error("upper address bits not zero");

    a_mode_decode: assert property (s_capture |->
        rmii_mode_en == ($past(pad_sync[5:3]) == 3'h1) &&
        rmii_b2b_en == ($past(pad_sync[5:3]) == 3'h5))
        else $error("mode decode wrong");

    a_ctrl_seed: assert property (s_capture |->
        isolate_en == $past(pad_sync[IDX_ISOLATE_STRAP]) &&
        duplex_half == $past(pad_sync[IDX_DUPLEX_STRAP]))
        else $error("isolate or duplex not seeded");

    a_speed_seed: assert property (s_capture |->
        speed_100 == $past(pad_sync[IDX_SPEED_STRAP])
        && cfg.adv[8:7] == {2{$past(pad_sync[IDX_SPEED_STRAP])}})
        else $error("speed not seeded");

    a_an_seed: assert property (s_capture |->
        autoneg_en == $past(pad_sync[IDX_AUTONEG_ENABLE_STRAP]))
        else $error("autoneg not seeded");

    a_nand_seed: assert property (s_capture |->
        nand_tree_en == !$past(pad_sync[IDX_NAND_TREE_STRAP_N]))
        else $error("nand tree strap not captured");

    a_bcast_seed: assert property (s_capture |->
        bcast_dis_r == $past(pad_sync[IDX_BROADCAST_DISABLE_STRAP]))
        else $error("broadcast disable strap not captured");

    a_mode_onehot: assert property (valid_r |->
        $onehot({rmii_mode_en, rmii_b2b_en, mode_reserved}))
        else $error("mode decode not one-hot");

    a_latch_hold: assert property (s_settled |-> $stable(phy_addr) && $stable(mode_r) &&
        $stable(bcast_dis_r) && $stable(nand_tree_en))
        else $error("latched strap changed");

    // ------------------------------------------------------------------
    // address match checks
    // ------------------------------------------------------------------

    a_bcast_zero: assert property (valid_r && !bcast_dis_r && mgmt_frame_addr == 5'h00
        |-> mgmt_addr_hit)
        else $error("broadcast address zero missed");

    a_unique_zero: assert property (valid_r && bcast_dis_r && mgmt_frame_addr == 5'h00
        |-> mgmt_addr_hit == (phy_addr == 5'h00))
        else $error("address zero not unique");

    a_hit_own: assert property (valid_r && mgmt_frame_addr == phy_addr
        |-> mgmt_addr_hit)
        else $error("own address missed");

    a_hit_foreign: assert property (mgmt_frame_addr != phy_addr
        && (mgmt_frame_addr != MGMT_ADDR_BCAST || bcast_dis_r) |-> !mgmt_addr_hit)
        else $error("foreign address accepted");

    a_hit_idle: assert property (!valid_r |-> !mgmt_addr_hit)
        else $error("address match before capture");

    // ------------------------------------------------------------------
    // pad direction checks
    // ------------------------------------------------------------------

    a_pad_input: assert property (!valid_r |-> strap_pad_oe == '0 ##1
        valid_r |-> strap_pad_oe == '1)
        else $error("pad direction wrong");

    a_pad_drive: assert property (s_settled |-> strap_pad_oe == '1
        && strap_pad_out == $past(func_out))
        else $error("pad not driving its function");

    // ------------------------------------------------------------------
    // register bus checks
    // ------------------------------------------------------------------
    sequence s_request;
        wb_cyc_i && wb_stb_i && !wb_ack_o && valid_r;
    endsequence

    sequence s_quiet;
        valid_r && !(wb_cyc_i && wb_stb_i && wb_we_i);
    endsequence

    sequence s_read(logic [7:0] ofs);
        wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && valid_r && wb_adr_i == ofs;
    endsequence

    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    a_ack_answer: assert property (s_request |=> wb_ack_o)
        else $error("request not answered");

    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && valid_r))
        else $error("ack without request");

    a_ctrl_hold: assert property (s_quiet |=>
        $stable(cfg.ctrl) && $stable(cfg.adv))
        else $error("control bits changed without a write");

    a_read_ctrl: assert property (s_read(OFS_BASIC_CTRL) |=>
        wb_dat_o == {16'h0000, $past(cfg.ctrl)})
        else $error("control read data wrong");

    a_read_status: assert property (s_read(OFS_STRAP_STATUS) |=>
        wb_dat_o == {16'h0000, $past(cfg.status)})
        else $error("status read data wrong");

    a_read_unmapped: assert property (s_read(8'h0c) |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");

    a_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper read lanes not zero");

endmodule

// [strap_board.sv]
/*
 * board side of the strap pads: pull resistors seen while the pads float.
 * assumes the device enable pad_oe high means the device drives the pad.
 */
`timescale 1ns/1ps
module strap_board (
    input wire logic [11:0] pull_level,
    input wire logic [11:0] pad_out,
    input wire logic [11:0] pad_oe,
    output logic [11:0] pad_level
);
    // ------------------------------------------------------------------
    // pad resolution
    // ------------------------------------------------------------------
    // pulls win while released, device wins when driving
    // pull_level carries the strap set each test applies, reserved mode codes 110 and 000 included
    assign pad_level = (pad_oe & pad_out) | (~pad_oe & pull_level);
endmodule

// [tb.sv]
/*
 * self-checking bench for the strap latch: resets with several strap
 * sets, checks latched outputs, registers and pad hand-back.
 * assumes strap_pkg and the design files are compiled first.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb;
    import strap_pkg::*;
    logic clk, nrst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, mgmt_addr_hit, straps_valid;
    logic [7:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [3:0] wb_sel_i;
    logic [11:0] pads, pad_out, pad_oe, func_out, pulls;
    logic [4:0] mgmt_frame_addr, phy_addr;
    logic rmii_mode_en, rmii_b2b_en, mode_reserved, isolate_en, speed_100;
    logic duplex_half, autoneg_en, nand_tree_en;
    logic [11:0] cases [4] = '{12'hb88, 12'h46f, 12'heb5, 12'hd40};
    logic [2:0] a, m;
    logic [15:0] ctl, st;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;

    phy_strap_latch_rmii dut_u (.clk(clk), .nrst(nrst), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .strap_pad_in(pads),
        .strap_pad_out(pad_out), .strap_pad_oe(pad_oe), .func_out(func_out),
        .mgmt_frame_addr(mgmt_frame_addr), .mgmt_addr_hit(mgmt_addr_hit),
        .straps_valid(straps_valid), .phy_addr(phy_addr), .rmii_mode_en(rmii_mode_en),
        .rmii_b2b_en(rmii_b2b_en), .mode_reserved(mode_reserved), .isolate_en(isolate_en),
        .speed_100(speed_100), .duplex_half(duplex_half), .autoneg_en(autoneg_en),
        .nand_tree_en(nand_tree_en));
    strap_board board_u (.pull_level(pulls), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_level(pads));

    // ------------------------------------------------------------------
    // clock, timeout, verdict
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task final_report;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles >= 5000) begin
            n_fail++;
            final_report();
        end
    end

    // ------------------------------------------------------------------
    // bus and reset tasks
    // ------------------------------------------------------------------
    task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d,
            output logic [31:0] q);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= ad;
        wb_dat_i <= d;
        wb_sel_i <= 4'h3;
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task automatic hit(input logic [4:0] ad, input logic e);
        @(posedge clk);
        mgmt_frame_addr <= ad;
        @(negedge clk);
        `CHK("addr_hit", e, mgmt_addr_hit)
    endtask
    task automatic do_reset(input logic [11:0] s);
        int n;
        n = 0;
        @(posedge clk);
        nrst <= 1'b0;
        pulls <= s;
        repeat (4) @(posedge clk); // pads steady while held low
        @(negedge clk);
        `CHK("oe_in_reset", 12'h000, pad_oe)
        @(posedge clk);
        nrst <= 1'b1;
        while (straps_valid !== 1'b1 && n < 10) begin
            @(posedge clk);
            n++;
        end
        @(negedge clk);
        `CHK("valid", 1'b1, straps_valid)
        `CHK("oe_after", 12'hfff, pad_oe)
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0000_0000;
        wb_sel_i = 4'h0;
        func_out = 12'h000;
        mgmt_frame_addr = 5'h00;
        pulls = 12'h000;
        foreach (cases[i]) begin
            func_out <= 12'h000;
            do_reset(cases[i]);
            a = cases[i][2:0];
            m = cases[i][5:3];
            ctl = {2'b00, cases[i][7], cases[i][9], 1'b0, cases[i][6], 1'b0, cases[i][8],
                8'h00};
            st = {1'b1, 4'h0, (m != MODE_RMII && m != MODE_RMII_B2B), ~cases[i][11],
                cases[i][10], m, 2'b00, a};
            `CHK("phy_addr", {2'b00, a}, phy_addr)
            `CHK("rmii", (m == 3'h1), rmii_mode_en)
            `CHK("b2b", (m == 3'h5), rmii_b2b_en)
            `CHK("reserved", st[10], mode_reserved)
            `CHK("isolate", cases[i][6], isolate_en)
            `CHK("speed", cases[i][7], speed_100)
            `CHK("duplex", cases[i][8], duplex_half)
            `CHK("autoneg", cases[i][9], autoneg_en)
            `CHK("nand", ~cases[i][11], nand_tree_en)
            wb(1'b0, OFS_BASIC_CTRL, 32'h0000_0000, rd);
            `CHK("ctrl", {16'h0000, ctl}, rd)
            wb(1'b0, OFS_AN_ADVERT, 32'h0000_0000, rd);
            `CHK("adv", cases[i][7] ? 32'h0000_01e1 : 32'h0000_0061, rd)
            wb(1'b0, OFS_STRAP_STATUS, 32'h0000_0000, rd);
            `CHK("status", {16'h0000, st}, rd)
            hit({2'b00, a}, 1'b1);
            hit(5'h00, (a == 3'h0) || !cases[i][10]);
            hit({2'b10, a}, 1'b0);
            // pads handed back now carry the function values
            @(posedge clk);
            func_out <= ~cases[i];
            repeat (3) @(posedge clk);
            @(negedge clk);
            `CHK("pad_out", ~cases[i], pad_out)
            `CHK("addr_hold", {2'b00, a}, phy_addr)
            `CHK("nand_hold", ~cases[i][11], nand_tree_en)
            wb(1'b0, OFS_STRAP_STATUS, 32'h0000_0000, rd);
            `CHK("status_hold", {16'h0000, st}, rd)
            wb(1'b1, OFS_STRAP_STATUS, 32'hffff_ffff, rd);
            wb(1'b0, OFS_STRAP_STATUS, 32'h0000_0000, rd);
            `CHK("status_ro", {16'h0000, st}, rd)
            wb(1'b1, OFS_BASIC_CTRL, {16'h0000, ~ctl}, rd);
            wb(1'b0, OFS_BASIC_CTRL, 32'h0000_0000, rd);
            `CHK("ctrl_sw", {16'h0000, ~ctl & CTRL_WMASK}, rd)
            @(negedge clk);
            `CHK("iso_sw", ~cases[i][6], isolate_en)
            wb(1'b1, OFS_AN_ADVERT, 32'h0000_0000, rd);
            wb(1'b0, OFS_AN_ADVERT, 32'h0000_0000, rd);
            `CHK("adv_sw", {16'h0000, ADV_RESET & ~ADV_WMASK}, rd)
            wb(1'b0, 8'h0c, 32'h0000_0000, rd);
            `CHK("unmapped", 32'h0000_0000, rd)
        end
        final_report();
    end
endmodule
